// ### logic/auxrr_pkg.sv
// How it works
// - Low internal reference low byte reads at 0x05b9.
// - Second bandgap high byte reads at 0x05ba.
// - Second bandgap low byte reads at 0x05bb.
// - Reading bandgap high byte freezes its low byte until both are read.
// - Always-on supply reference high byte at 0x05be, low byte at 0x05bf.
// - Reading always-on high byte freezes its low byte until both are read.
// - Analog supply reference high byte reads at 0x05c0.
// - Reading analog supply high byte freezes its low byte until both are read.
// - Reading low reference high byte freezes its low byte until both are read.
package auxrr_pkg;

    localparam int unsigned NUM_PAIRS = 4;
    localparam int unsigned ADDR_W    = 16;
    localparam int unsigned RES_W     = 16;

    localparam logic [15:0] OFS_LOWREF_HI  = 16'h05b8;
    localparam logic [15:0] OFS_LOWREF_LO  = 16'h05b9;
    localparam logic [15:0] OFS_BANDGAP_HI = 16'h05ba;
    localparam logic [15:0] OFS_BANDGAP_LO = 16'h05bb;
    localparam logic [15:0] OFS_AON_HI     = 16'h05be;
    localparam logic [15:0] OFS_AON_LO     = 16'h05bf;
    localparam logic [15:0] OFS_ASUP_HI    = 16'h05c0;
    localparam logic [15:0] OFS_ASUP_LO    = 16'h05c1;

    localparam logic [7:0] RST_HIGH = 8'h80;
    localparam logic [7:0] RST_LOW  = 8'h00;
    localparam logic [7:0] RD_NONE  = 8'h00;

    // Converter channel code that selects which pair a finished conversion loads
    typedef enum logic [1:0] {
        CH_LOW_INT_REF   = 2'h0,
        CH_BANDGAP2      = 2'h1,
        CH_ALWAYS_ON     = 2'h2,
        CH_ANALOG_SUPPLY = 2'h3
    } auxrr_chan_t;

    function automatic logic [15:0] high_ofs(input logic [1:0] idx);
        logic [15:0] ofs;
        ofs = OFS_LOWREF_HI;
        case (idx)
            2'h0: ofs = OFS_LOWREF_HI;
            2'h1: ofs = OFS_BANDGAP_HI;
            2'h2: ofs = OFS_AON_HI;
            2'h3: ofs = OFS_ASUP_HI;
            default: ofs = OFS_LOWREF_HI;
        endcase
        return ofs;
    endfunction

    function automatic logic [15:0] low_ofs(input logic [1:0] idx);
        logic [15:0] ofs;
        ofs = OFS_LOWREF_LO;
        case (idx)
            2'h0: ofs = OFS_LOWREF_LO;
            2'h1: ofs = OFS_BANDGAP_LO;
            2'h2: ofs = OFS_AON_LO;
            2'h3: ofs = OFS_ASUP_LO;
            default: ofs = OFS_LOWREF_LO;
        endcase
        return ofs;
    endfunction

endpackage

// ### logic/auxrr_pair.sv
module auxrr_pair (
    input  wire logic        core_clk_in,
    input  wire logic        sys_rst_in,
    input  wire logic [15:0] result_in,
    input  wire logic        sample_in,
    input  wire logic        rd_high_in,
    input  wire logic        rd_low_in,
    output logic      [7:0]  high_out,
    output logic      [7:0]  low_out,
    output logic             lock_out
);

    typedef struct packed {
        logic [7:0] high;
        logic [7:0] low;
        logic       lock;
    } auxrr_pair_t;

    auxrr_pair_t s_q;
    auxrr_pair_t s_d;

    always_comb begin
        s_d = s_q;
        if (sample_in) begin
            s_d.high = result_in[15:8];
            // A high read in this very cycle also blocks the low byte, so the
            // low byte stays paired with the high byte being returned
            if (!(s_q.lock || rd_high_in)) begin
                s_d.low = result_in[7:0];
            end
        end
        if (rd_high_in) begin
            s_d.lock = 1'b1;
        end else if (rd_low_in) begin
            s_d.lock = 1'b0;
        end
    end

    always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            s_q <= '{high: auxrr_pkg::RST_HIGH, low: auxrr_pkg::RST_LOW, lock: 1'b0};
        end else begin
            s_q <= s_d;
        end
    end

    assign high_out = s_q.high;
    assign low_out  = s_q.low;
    assign lock_out = s_q.lock;

endmodule

// ### logic/auxrr_regs.sv
module auxrr_regs (
    input  wire logic        core_clk_in,
    input  wire logic        sys_rst_in,
    input  wire logic [15:0] reg_addr_in,
    input  wire logic [7:0]  reg_wdata_in,
    input  wire logic        reg_wr_in,
    input  wire logic        reg_rd_in,
    output logic      [7:0]  reg_rdata_out,
    input  wire logic        conv_valid_in,
    input  wire logic [1:0]  conv_chan_in,
    input  wire logic [15:0] conv_result_in,
    output logic      [3:0]  lock_out
);

    typedef struct packed {
        logic [7:0] rdata;
    } auxrr_top_t;

    auxrr_top_t s_q;
    auxrr_top_t s_d;

    logic [7:0] high_w [auxrr_pkg::NUM_PAIRS];
    logic [7:0] low_w  [auxrr_pkg::NUM_PAIRS];
    logic [3:0] lock_w;
    logic [3:0] rd_high_w;
    logic [3:0] rd_low_w;
    logic [3:0] sample_w;

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_pair
            assign rd_high_w[gi] = reg_rd_in &&
                (reg_addr_in == auxrr_pkg::high_ofs(2'(gi)));
            assign rd_low_w[gi]  = reg_rd_in &&
                (reg_addr_in == auxrr_pkg::low_ofs(2'(gi)));
            assign sample_w[gi]  = conv_valid_in && (conv_chan_in == 2'(gi));

            auxrr_pair u_pair (
                .core_clk_in (core_clk_in),
                .sys_rst_in  (sys_rst_in),
                .result_in   (conv_result_in),
                .sample_in   (sample_w[gi]),
                .rd_high_in  (rd_high_w[gi]),
                .rd_low_in   (rd_low_w[gi]),
                .high_out    (high_w[gi]),
                .low_out     (low_w[gi]),
                .lock_out    (lock_w[gi])
            );
        end
    endgenerate

    // Write data is accepted and dropped: every register here is read-only
    logic wr_unused;
    assign wr_unused = reg_wr_in & (|reg_wdata_in);

    always_comb begin
        s_d = s_q;
        s_d.rdata = auxrr_pkg::RD_NONE;
        if (reg_rd_in) begin
            unique case (reg_addr_in)
                auxrr_pkg::OFS_LOWREF_HI:  s_d.rdata = high_w[0];
                auxrr_pkg::OFS_LOWREF_LO:  s_d.rdata = low_w[0];
                auxrr_pkg::OFS_BANDGAP_HI: s_d.rdata = high_w[1];
                auxrr_pkg::OFS_BANDGAP_LO: s_d.rdata = low_w[1];
                auxrr_pkg::OFS_AON_HI:     s_d.rdata = high_w[2];
                auxrr_pkg::OFS_AON_LO:     s_d.rdata = low_w[2];
                auxrr_pkg::OFS_ASUP_HI:    s_d.rdata = high_w[3];
                auxrr_pkg::OFS_ASUP_LO:    s_d.rdata = low_w[3];
                default:                   s_d.rdata = auxrr_pkg::RD_NONE;
            endcase
        end
    end

    always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            s_q <= '{rdata: auxrr_pkg::RD_NONE};
        end else begin
            s_q <= s_d;
        end
    end

    assign reg_rdata_out = s_q.rdata;
    assign lock_out      = lock_w;

    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (sys_rst_in);

    logic rd_aon_lo_w;
    assign rd_aon_lo_w = reg_rd_in && (reg_addr_in == auxrr_pkg::OFS_AON_LO);

    lowref_low_rd_a: assert property (
        reg_rd_in && reg_addr_in == auxrr_pkg::OFS_LOWREF_LO
        |=> reg_rdata_out == $past(low_w[0]))
        else $error("low reference low byte read returned wrong value");

    bandgap_high_rd_a: assert property (
        reg_rd_in && reg_addr_in == auxrr_pkg::OFS_BANDGAP_HI
        |=> reg_rdata_out == $past(high_w[1]))
        else $error("bandgap high byte read returned wrong value");

    bandgap_low_rd_a: assert property (
        reg_rd_in && reg_addr_in == auxrr_pkg::OFS_BANDGAP_LO
        |=> reg_rdata_out == $past(low_w[1]))
        else $error("bandgap low byte read returned wrong value");

    bandgap_freeze_a: assert property (
        reg_rd_in && reg_addr_in == auxrr_pkg::OFS_BANDGAP_HI
        |=> lock_w[1] && $stable(low_w[1]))
        else $error("bandgap low byte not frozen after high read");

    aon_pair_rd_a: assert property (
        reg_rd_in && (reg_addr_in == auxrr_pkg::OFS_AON_HI || rd_aon_lo_w)
        |=> reg_rdata_out == $past(rd_aon_lo_w ? low_w[2] : high_w[2]))
        else $error("always-on reference read returned wrong value");

    aon_freeze_a: assert property (
        lock_w[2] && !rd_aon_lo_w |=> $stable(low_w[2]) && lock_w[2])
        else $error("always-on low byte changed while frozen");

    asup_high_rd_a: assert property (
        reg_rd_in && reg_addr_in == auxrr_pkg::OFS_ASUP_HI
        |=> reg_rdata_out == $past(high_w[3]))
        else $error("analog supply high byte read returned wrong value");

    asup_freeze_a: assert property (
        rd_high_w[3] ##1 (!rd_low_w[3])[*2] |-> lock_w[3] && $stable(low_w[3]))
        else $error("analog supply low byte changed while frozen");

    lowref_freeze_a: assert property (
        rd_high_w[0] |=> lock_w[0] && low_w[0] == $past(low_w[0]))
        else $error("low reference low byte not frozen after high read");

    write_ignored_a: assert property (
        reg_wr_in && !conv_valid_in
        |=> $stable(high_w[0]) && $stable(low_w[1]) && $stable(high_w[3])
            && $stable(lock_w))
        else $error("register write changed a result register");

    freeze_release_a: assert property (
        lock_w[1] && rd_low_w[1] |=> !lock_w[1])
        else $error("bandgap freeze not released by low byte read");

    unmapped_rd_a: assert property (
        reg_rd_in && rd_high_w == 4'h0 && rd_low_w == 4'h0
        |=> reg_rdata_out == auxrr_pkg::RD_NONE)
        else $error("unmapped read did not return zero");

    // Most checks here decode the bus by constant address, not through the pair
    // select wires, so a slip in the shared offset functions is still caught
    reset_bus_a: assert property (disable iff (1'b0)
        sys_rst_in ##1 sys_rst_in
        |-> reg_rdata_out == auxrr_pkg::RD_NONE && lock_out == 4'h0)
        else $error("bus side left reset with wrong values");

    rdata_idle_a: assert property (
        !reg_rd_in |=> reg_rdata_out == auxrr_pkg::RD_NONE)
        else $error("read data not zero outside a read answer");

    wr_rdata_a: assert property (
        reg_wr_in |=> reg_rdata_out == auxrr_pkg::RD_NONE)
        else $error("register write produced read data");

    no_rd_lock_a: assert property (
        !reg_rd_in |=> $stable(lock_w))
        else $error("freeze flag moved without a read");

    lowref_high_rd_a: assert property (
        reg_rd_in && reg_addr_in == auxrr_pkg::OFS_LOWREF_HI
        |=> reg_rdata_out == $past(high_w[0]))
        else $error("low reference high byte read returned wrong value");

    asup_low_rd_a: assert property (
        reg_rd_in && reg_addr_in == auxrr_pkg::OFS_ASUP_LO
        |=> reg_rdata_out == $past(low_w[3]))
        else $error("analog supply low byte read returned wrong value");

    hole_rd_a: assert property (
        reg_rd_in && (reg_addr_in == 16'h05bc || reg_addr_in == 16'h05bd)
        |=> reg_rdata_out == auxrr_pkg::RD_NONE)
        else $error("read between pairs did not return zero");

    conv_high_a: assert property (
        conv_valid_in
        |=> high_w[$past(conv_chan_in)] == $past(conv_result_in[15:8]))
        else $error("conversion did not load its high byte");

    conv_low_a: assert property (
        conv_valid_in && !lock_w[conv_chan_in]
            && !(reg_rd_in && reg_addr_in == auxrr_pkg::high_ofs(conv_chan_in))
        |=> low_w[$past(conv_chan_in)] == $past(conv_result_in[7:0]))
        else $error("unfrozen conversion did not load its low byte");

    pair_read_c: cover property (
        rd_high_w[1] ##1 conv_valid_in ##1 rd_low_w[1]);
    frozen_sample_c: cover property (
        lock_w[2] && sample_w[2]);
    same_cycle_c: cover property (
        rd_high_w[3] && sample_w[3]);
    lone_low_rd_c: cover property (
        !lock_w[0] && rd_low_w[0]);
    gap_read_c: cover property (
        rd_high_w[2] ##1 !rd_low_w[2] ##1 rd_low_w[2]);

    // Every pair runs the same freeze protocol, so its checks are written once
    genvar ci;
    generate
        for (ci = 0; ci < 4; ci++) begin : g_chk
            reset_val_a: assert property (disable iff (1'b0)
                sys_rst_in ##1 sys_rst_in
                |-> high_w[ci] == auxrr_pkg::RST_HIGH && low_w[ci] == auxrr_pkg::RST_LOW
                    && !lock_w[ci])
                else $error("result pair left reset with wrong values");

            high_load_a: assert property (
                sample_w[ci]
                |=> high_w[ci] == $past(conv_result_in[15:8]))
                else $error("conversion did not load the high byte");

            low_load_a: assert property (
                sample_w[ci] && !lock_w[ci] && !rd_high_w[ci]
                |=> low_w[ci] == $past(conv_result_in[7:0]))
                else $error("unfrozen conversion did not load the low byte");

            low_block_a: assert property (
                lock_w[ci] || rd_high_w[ci]
                |=> $stable(low_w[ci]))
                else $error("frozen low byte changed");

            high_free_a: assert property (
                lock_w[ci] && sample_w[ci]
                |=> high_w[ci] == $past(conv_result_in[15:8]))
                else $error("high byte stopped updating while frozen");

            idle_hold_a: assert property (
                !sample_w[ci]
                |=> $stable(high_w[ci]) && $stable(low_w[ci]))
                else $error("result byte changed without a conversion");

            other_chan_a: assert property (
                conv_valid_in && conv_chan_in != 2'(ci)
                |=> $stable(high_w[ci]) && $stable(low_w[ci]))
                else $error("conversion loaded the wrong pair");

            wr_keep_a: assert property (
                reg_wr_in && !sample_w[ci]
                |=> $stable(high_w[ci]) && $stable(low_w[ci]) && $stable(lock_w[ci]))
                else $error("register write changed a result pair");

            lock_set_a: assert property (
                rd_high_w[ci]
                |=> lock_w[ci])
                else $error("high byte read did not freeze the low byte");

            relock_a: assert property (
                lock_w[ci] && rd_high_w[ci]
                |=> lock_w[ci] && $stable(low_w[ci]))
                else $error("second high byte read released the freeze");

            lock_clear_a: assert property (
                rd_low_w[ci]
                |=> !lock_w[ci])
                else $error("low byte read did not release the freeze");

            lock_keep_a: assert property (
                !rd_high_w[ci] && !rd_low_w[ci]
                |=> $stable(lock_w[ci]))
                else $error("freeze flag moved without a read of its pair");

            lock_rise_a: assert property (
                !lock_w[ci] ##1 lock_w[ci]
                |-> $past(rd_high_w[ci]))
                else $error("freeze set without a high byte read");

            lock_fall_a: assert property (
                lock_w[ci] ##1 !lock_w[ci]
                |-> $past(rd_low_w[ci]))
                else $error("freeze released without a low byte read");

            high_rd_a: assert property (
                rd_high_w[ci]
                |=> reg_rdata_out == $past(high_w[ci]))
                else $error("high byte read returned wrong value");

            low_rd_a: assert property (
                rd_low_w[ci]
                |=> reg_rdata_out == $past(low_w[ci]))
                else $error("low byte read returned wrong value");

            // The low read must return the low byte as it stood at the high read
            pair_match_a: assert property (
                rd_high_w[ci] ##1 rd_low_w[ci]
                |=> reg_rdata_out == $past(low_w[ci], 2))
                else $error("back to back pair read did not match");

            pair_gap_a: assert property (
                rd_high_w[ci] ##1 !rd_low_w[ci] ##1 rd_low_w[ci]
                |=> reg_rdata_out == $past(low_w[ci], 3))
                else $error("pair read with one idle cycle did not match");

            pair_gap2_a: assert property (
                rd_high_w[ci] ##1 (!rd_low_w[ci])[*2] ##1 rd_low_w[ci]
                |=> reg_rdata_out == $past(low_w[ci], 4))
                else $error("pair read with two idle cycles did not match");
        end
    endgenerate

endmodule

// ### tb/auxrr_regs_tb.sv
module auxrr_regs_tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic        core_clk_in    = 1'b0;
    logic        sys_rst_in     = 1'b1;
    logic [15:0] reg_addr_in    = 16'h0000;
    logic [7:0]  reg_wdata_in   = 8'h00;
    logic        reg_wr_in      = 1'b0;
    logic        reg_rd_in      = 1'b0;
    logic        conv_valid_in  = 1'b0;
    logic [1:0]  conv_chan_in   = 2'h0;
    logic [15:0] conv_result_in = 16'h0000;
    logic [7:0]  reg_rdata_out;
    logic [3:0]  lock_out;
    int          err_count      = 0;
    int          tests_run      = 0;
    logic [7:0]  hi_m[4];
    logic [7:0]  lo_m[4];
    bit          lk_m[4];
    logic [7:0]  exp_q          = 8'h00;
    logic [3:0]  lk_q           = 4'h0;
    // Pairs in channel order, high then low; the last two are unmapped (a hole between pairs and the address past the map)
    logic [15:0] am[10] = '{auxrr_pkg::OFS_LOWREF_HI, auxrr_pkg::OFS_LOWREF_LO,
        auxrr_pkg::OFS_BANDGAP_HI, auxrr_pkg::OFS_BANDGAP_LO, auxrr_pkg::OFS_AON_HI,
        auxrr_pkg::OFS_AON_LO, auxrr_pkg::OFS_ASUP_HI, auxrr_pkg::OFS_ASUP_LO,
        16'h05bc, 16'h05c2};

    auxrr_regs dut (
        .core_clk_in    (core_clk_in),
        .sys_rst_in     (sys_rst_in),
        .reg_addr_in    (reg_addr_in),
        .reg_wdata_in   (reg_wdata_in),
        .reg_wr_in      (reg_wr_in),
        .reg_rd_in      (reg_rd_in),
        .reg_rdata_out  (reg_rdata_out),
        .conv_valid_in  (conv_valid_in),
        .conv_chan_in   (conv_chan_in),
        .conv_result_in (conv_result_in),
        .lock_out       (lock_out)
    );

    always #12.5 core_clk_in = ~core_clk_in;

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_count++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    // One bus cycle; the read answer and lock flags of the previous cycle are checked
    task automatic cyc(input logic rd, input logic wr, input logic [15:0] a,
                       input logic [7:0] wd, input logic cv, input logic [1:0] ch,
                       input logic [15:0] r);
        logic [7:0] cur;
        bit         ol;
        bit         hrd;
        logic [3:0] lks;
        @(posedge core_clk_in);
        reg_rd_in      <= rd;
        reg_wr_in      <= wr;
        reg_addr_in    <= a;
        reg_wdata_in   <= wd;
        conv_valid_in  <= cv;
        conv_chan_in   <= ch;
        conv_result_in <= r;
        cur = 8'h00;
        ol  = lk_m[ch];
        hrd = rd && (a == am[2 * ch]);
        for (int i = 0; i < 8; i++) begin
            if (rd && a == am[i]) begin
                cur = i[0] ? lo_m[i / 2] : hi_m[i / 2];
                lk_m[i / 2] = !i[0];
            end
        end
        if (cv) begin
            hi_m[ch] = r[15:8];
            if (!ol && !hrd) begin
                lo_m[ch] = r[7:0];
            end
        end
        lks = {lk_m[3], lk_m[2], lk_m[1], lk_m[0]};
        @(negedge core_clk_in);
        chk(reg_rdata_out, exp_q);
        chk({4'h0, lock_out}, {4'h0, lk_q});
        exp_q = cur;
        lk_q  = lks;
    endtask

    task automatic rd_t(input logic [15:0] a);
        cyc(1'b1, 1'b0, a, 8'h00, 1'b0, 2'h0, 16'h0000);
    endtask

    task automatic final_report();
        $display("Comparisons %0d, mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    initial begin
        int k;
        logic [15:0] v1;
        logic [15:0] v2;
        void'($urandom(32'h1f5c));
        for (int c = 0; c < 4; c++) begin
            hi_m[c] = auxrr_pkg::RST_HIGH;
            lo_m[c] = auxrr_pkg::RST_LOW;
            lk_m[c] = 1'b0;
        end
        repeat (2) @(posedge core_clk_in);
        sys_rst_in <= 1'b0;
        for (int i = 0; i < 10; i++) rd_t(am[i]);
        $display("test reset_values done");
        for (int i = 0; i < 10; i++) cyc(1'b0, 1'b1, am[i], 8'($urandom), 1'b0, 2'h0, 16'h0);
        for (int i = 0; i < 10; i++) rd_t(am[i]);
        $display("test write_ignored done");
        // Freeze, re-lock, release, and a high read in the same cycle as a conversion
        for (int c = 0; c < 4; c++) begin
            v1 = 16'($urandom);
            v2 = 16'($urandom);
            // Low bytes differ by construction, so a missed freeze always shows
            v2[7:0] = ~v1[7:0];
            cyc(1'b0, 1'b0, 16'h0, 8'h00, 1'b1, 2'(c), v1);
            rd_t(am[2 * c]);
            cyc(1'b0, 1'b0, 16'h0, 8'h00, 1'b1, 2'(c), v2);
            rd_t(am[2 * c]);
            rd_t(am[2 * c + 1]);
            rd_t(am[2 * c + 1]);
            cyc(1'b1, 1'b0, am[2 * c], 8'h00, 1'b1, 2'(c), ~v1);
            rd_t(am[2 * c + 1]);
            cyc(1'b0, 1'b0, 16'h0, 8'h00, 1'b1, 2'(c), v1 ^ 16'h5a5a);
            rd_t(am[2 * c + 1]);
        end
        $display("test freeze_pairs done");
        repeat (600) begin
            k = $urandom % 4;
            cyc(k == 0, k == 1, am[$urandom % 10], 8'($urandom), 1'($urandom),
                2'($urandom), 16'($urandom));
        end
        $display("test random_traffic done");
        rd_t(16'h0000);
        rd_t(16'h0000);
        final_report();
    end
endmodule
